// ### design/crirq_pkg.sv
// Package of constants for the card reader interrupt and status block
// Function
// - A grounded acknowledge-inhibit strap suppresses the slave acknowledge.
// - Vector defaults to octal 230 from jumpers in bits 3, 4 and 7.
// - A fitted vector jumper gives a one, an absent jumper a zero.
// - Second request channel stays disabled; vector bit 2 is zero, vector 230.
// - Request only while request condition and channel A enable are both high.
// - Writing one to status bit 06 sets the interrupt enable.
// - Request condition is OR of error, card done, went online, column available.
// - Both inputs asserted raise the bus request of the priority plug, BR6 default.
// - Grant answered by SACK; BBSY asserted once BBSY, SSYN, BG are false.
// - Vector bits 0 and 1 undriven; lowest selectable line from bit-2 flop.
// - Incoming grant passes to outgoing grant while not requesting, not in SACK and not bus master.
// - Mastership released after vector strobe; conditions hold until software clears them.
// - No new request until condition or enable drops and rises again.
// - Never issues non-processor requests; jumper intact holds off while NPR pending.
// - Status register is 16 bits wide with ten unused positions.
// - Ready falling edge sets offline flop, clears read flop; error in bit 15.
// - Read command written while ready low leaves offline flop set.
// - Read-command flop held cleared while ready is low.
// - Read-command flop state is not readable by software.
// - Error bit also reads one when overrun and card done are both set.
// - Card in reader negated with read flop clear sets card done, bit 14.
// - Ready rising edge sets the went-online flag.
package crirq_pkg;
  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int unsigned CRIRQ_ST_WIDTH = 16;
  localparam int unsigned CRIRQ_B_ERROR = 15;
  localparam int unsigned CRIRQ_B_DONE = 14;
  localparam int unsigned CRIRQ_B_ONLINE = 10;
  localparam int unsigned CRIRQ_B_COLRDY = 7;
  localparam int unsigned CRIRQ_B_INTEN = 6;
  localparam int unsigned CRIRQ_B_READ = 0;
  localparam logic [15:0] CRIRQ_ST_RESET = 16'h0000;
  // ****************************************************************
  // Interrupt vector and bus request level
  // ****************************************************************
  // Jumper pattern for vector bits 7..3: octal 230 fits bits 7, 4, 3
  localparam logic [4:0] CRIRQ_VEC_JUMPERS = 5'h13;
  localparam logic [7:0] CRIRQ_VEC_DEFAULT = 8'h98;
  localparam int unsigned CRIRQ_BR_LEVELS = 4;
  // Priority plug: index 2 of BR4..BR7 is BR6
  localparam logic [1:0] CRIRQ_PRIO_PLUG = 2'h2;
  typedef enum logic [1:0] {
    CRIRQ_IDLE,
    CRIRQ_REQ,
    CRIRQ_SACK,
    CRIRQ_MASTER
  } crirq_state_t;
endpackage : crirq_pkg

// ### design/crirq_vector.sv
// Interrupt vector formation from jumpers and the channel select flop
`timescale 1ns/100ps
`default_nettype none
module crirq_vector
  import crirq_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic load,
  output logic [7:0] vector_q
);
  // ****************************************************************
  // Second channel tied off
  // ****************************************************************
  // Channel B request and enable are grounded, so its flop never sets
  logic channel_b_request;
  logic channel_b_enable;
  logic vector_bit2_flop;
  assign channel_b_request = 1'b0;
  assign channel_b_enable = 1'b0;

  always_ff @(posedge clk) begin
    if (clr) begin
      vector_bit2_flop <= 1'b0;
    end else if (load) begin
      vector_bit2_flop <= channel_b_request & channel_b_enable;
    end
  end

  // ****************************************************************
  // Selectable vector lines
  // ****************************************************************
  logic [7:0] vec_d;
  assign vec_d[1:0] = 2'h0;
  assign vec_d[2] = vector_bit2_flop;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_jmp
      // Fitted jumper reads as one
      assign vec_d[gi + 3] = CRIRQ_VEC_JUMPERS[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (clr) begin
      vector_q <= 8'h00;
    end else if (load) begin
      vector_q <= vec_d;
    end
  end
endmodule : crirq_vector
`default_nettype wire

// ### design/crirq_core.sv
// Card reader interrupt request logic and error and card-done status
`timescale 1ns/100ps
`default_nettype none
module crirq_core
  import crirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_init,
  input wire logic ack_inhibit_strap,
  input wire logic status_sel,
  input wire logic status_rd,
  input wire logic status_wr_lo,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic slave_ack,
  input wire logic reader_ready_line,
  input wire logic card_in_reader,
  input wire logic index_marker,
  input wire logic column_available_flag,
  input wire logic overrun_flag,
  output logic read_cmd,
  input wire logic npr_sample_jumper,
  input wire logic npr_in,
  input wire logic bg_in,
  input wire logic bbsy_in,
  input wire logic ssyn_in,
  output logic [3:0] br_out,
  output logic bg_out,
  output logic sack_out,
  output logic bbsy_out,
  output logic intr_out,
  output logic [7:0] vector_out
);
  // ****************************************************************
  // Reset and edge detection
  // ****************************************************************
  logic clr;
  logic ready_prev_q;
  logic cir_prev_q;
  logic ready_fell;
  logic ready_rose;
  logic cir_fell;
  assign clr = sys_rst | bus_init;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_prev_q <= 1'b0;
      cir_prev_q <= 1'b0;
    end else begin
      ready_prev_q <= reader_ready_line;
      cir_prev_q <= card_in_reader;
    end
  end

  assign ready_fell = ready_prev_q & ~reader_ready_line;
  assign ready_rose = ~ready_prev_q & reader_ready_line;
  assign cir_fell = cir_prev_q & ~card_in_reader;

  // ****************************************************************
  // Status flops
  // ****************************************************************
  logic wr_st;
  logic read_cmd_q;
  logic offline_q;
  logic card_complete_q;
  logic went_online_q;
  logic int_enable_q;
  logic error_bit;
  assign wr_st = status_sel & status_wr_lo;

  // Dropped ready forces the read flop clear so no command escapes
  always_ff @(posedge clk) begin
    if (clr) begin
      read_cmd_q <= 1'b0;
    end else if (!reader_ready_line || ready_fell) begin
      read_cmd_q <= 1'b0;
    end else if (wr_st && bus_wdata[CRIRQ_B_READ]) begin
      read_cmd_q <= 1'b1;
    end else if (index_marker) begin
      read_cmd_q <= 1'b0;
    end
  end
  assign read_cmd = read_cmd_q;

  // Interlock: a read command written while offline keeps the error
  always_ff @(posedge clk) begin
    if (clr) begin
      offline_q <= 1'b0;
    end else if (ready_fell) begin
      offline_q <= 1'b1;
    end else if (wr_st && !(bus_wdata[CRIRQ_B_READ] && !reader_ready_line)) begin
      offline_q <= 1'b0;
    end
  end

  // Set wins over the clearing write in the same cycle
  always_ff @(posedge clk) begin
    if (clr) begin
      card_complete_q <= 1'b0;
    end else if (cir_fell && !read_cmd_q) begin
      card_complete_q <= 1'b1;
    end else if (wr_st) begin
      card_complete_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      went_online_q <= 1'b0;
    end else if (ready_rose) begin
      went_online_q <= 1'b1;
    end else if (wr_st) begin
      went_online_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      int_enable_q <= 1'b0;
    end else if (wr_st) begin
      int_enable_q <= bus_wdata[CRIRQ_B_INTEN];
    end
  end

  assign error_bit = offline_q | (overrun_flag & card_complete_q);

  // ****************************************************************
  // Register read and slave acknowledge
  // ****************************************************************
  // Ten positions (13..11, 9, 8, 5..1) handled elsewhere read zero here;
  // the read flop has no read path at all
  logic [15:0] status_word;
  logic ack_q;
  always_comb begin
    status_word = CRIRQ_ST_RESET;
    status_word[CRIRQ_B_ERROR] = error_bit;
    status_word[CRIRQ_B_DONE] = card_complete_q;
    status_word[CRIRQ_B_ONLINE] = went_online_q;
    status_word[CRIRQ_B_COLRDY] = column_available_flag;
    status_word[CRIRQ_B_INTEN] = int_enable_q;
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      bus_rdata <= CRIRQ_ST_RESET;
    end else if (status_sel && status_rd) begin
      bus_rdata <= status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= status_sel & (status_rd | status_wr_lo) & ack_inhibit_strap;
    end
  end
  assign slave_ack = ack_q & ack_inhibit_strap;

  // ****************************************************************
  // Interrupt request and bus mastership
  // ****************************************************************
  logic irq_cond;
  logic want;
  logic armed_q;
  logic npr_hold;
  crirq_state_t state_q;
  assign irq_cond = error_bit | card_complete_q | went_online_q
                    | column_available_flag;
  assign want = irq_cond & int_enable_q;
  // Only waits on pending NPRs; this block never asks for one itself
  assign npr_hold = npr_sample_jumper & npr_in;

  // Re-armed only when the request inputs fall, so one event is one interrupt
  always_ff @(posedge clk) begin
    if (clr) begin
      armed_q <= 1'b1;
    end else if (state_q == CRIRQ_MASTER && ssyn_in) begin
      armed_q <= 1'b0;
    end else if (!want) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      state_q <= CRIRQ_IDLE;
    end else begin
      unique case (state_q)
        CRIRQ_IDLE: begin
          if (want && armed_q && !npr_hold) begin
            state_q <= CRIRQ_REQ;
          end
        end
        CRIRQ_REQ: begin
          if (!want) begin
            state_q <= CRIRQ_IDLE;
          end else if (bg_in) begin
            state_q <= CRIRQ_SACK;
          end
        end
        CRIRQ_SACK: begin
          if (!bbsy_in && !ssyn_in && !bg_in) begin
            state_q <= CRIRQ_MASTER;
          end
        end
        CRIRQ_MASTER: begin
          if (ssyn_in) begin
            state_q <= CRIRQ_IDLE;
          end
        end
      endcase
    end
  end

  // The request falls with its cause, so a withdrawn cause never holds the line
  logic requesting;
  assign requesting = (state_q == CRIRQ_REQ) & want;
  assign br_out = requesting ? 4'(4'h1 << CRIRQ_PRIO_PLUG) : 4'h0;
  // A grant that arrives after the cause is gone goes on down the chain
  assign bg_out = bg_in & ~requesting & (state_q != CRIRQ_SACK)
                  & (state_q != CRIRQ_MASTER);
  assign sack_out = (state_q == CRIRQ_SACK);
  assign bbsy_out = (state_q == CRIRQ_MASTER);
  assign intr_out = (state_q == CRIRQ_MASTER);

  crirq_vector u_vector (
    .clk(clk),
    .clr(clr),
    .load(state_q == CRIRQ_SACK),
    .vector_q(vector_out)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (clr);

  sequence s_granted;
    (state_q == CRIRQ_REQ) && bg_in ##1 sack_out;
  endsequence
  sequence s_bus_free;
    sack_out && !bbsy_in && !ssyn_in && !bg_in;
  endsequence
  sequence s_strobe;
    bbsy_out && ssyn_in;
  endsequence
  sequence s_may_request;
    state_q == CRIRQ_IDLE && armed_q && !npr_hold && int_enable_q;
  endsequence
  // Causes as software reads them, not as the request logic combines them
  sequence s_any_cause;
    status_word[CRIRQ_B_ERROR] || status_word[CRIRQ_B_DONE]
    || status_word[CRIRQ_B_ONLINE] || status_word[CRIRQ_B_COLRDY];
  endsequence

  ack_inhibit_a: assert property (
    !ack_inhibit_strap |-> !slave_ack) else $error("ack while inhibited");
  vector_value_a: assert property (
    intr_out |-> vector_out[7:3] == CRIRQ_VEC_JUMPERS) else $error("vector lines wrong");
  vector_bit2_a: assert property (
    intr_out |-> vector_out[2:0] == 3'h0) else $error("vector low bits set");
  request_gate_a: assert property (
    br_out != 4'h0 |-> irq_cond && int_enable_q) else $error("request without cause");
  request_level_a: assert property (
    (state_q == CRIRQ_IDLE && want && armed_q && !npr_hold) |=> br_out == (want ? 4'h4 : 4'h0))
    else $error("request not on level six");
  master_seq_a: assert property (
    s_granted ##[0:20] s_bus_free |=> bbsy_out) else $error("no BBSY after grant");
  grant_pass_a: assert property (
    br_out == 4'h0 && !sack_out && !bbsy_out |-> bg_out == bg_in)
    else $error("grant not passed");
  release_a: assert property (
    bbsy_out && ssyn_in |=> !bbsy_out ##1 br_out == 4'h0) else $error("bus not released");
  no_rerequest_a: assert property (
    $fell(bbsy_out) ##0 want [*2] |-> br_out == 4'h0) else $error("repeated request");
  npr_hold_a: assert property (
    state_q == CRIRQ_IDLE && npr_hold |=> br_out == 4'h0) else $error("request over NPR");
  offline_a: assert property (
    $fell(reader_ready_line) |=> offline_q && status_word[CRIRQ_B_ERROR])
    else $error("offline error missing");
  interlock_a: assert property (
    offline_q && wr_st && bus_wdata[0] && !reader_ready_line |=> offline_q)
    else $error("interlock cleared error");
  read_held_a: assert property (
    !reader_ready_line |=> !read_cmd) else $error("read while not ready");
  done_set_a: assert property (
    $fell(card_in_reader) && !read_cmd_q |=> card_complete_q)
    else $error("card done missed");
  online_a: assert property (
    $rose(reader_ready_line) |=> went_online_q) else $error("online flag missed");
  ack_give_a: assert property (
    status_sel && (status_rd || status_wr_lo) && ack_inhibit_strap ##1 ack_inhibit_strap
    |-> slave_ack) else $error("ack missing");
  enable_store_a: assert property (
    wr_st |=> int_enable_q == $past(bus_wdata[CRIRQ_B_INTEN]))
    else $error("enable write lost");
  cause_request_a: assert property (
    s_may_request ##0 s_any_cause |=> state_q == CRIRQ_REQ)
    else $error("cause gave no request");
  sack_answer_a: assert property (
    state_q == CRIRQ_REQ && want && bg_in |=> sack_out)
    else $error("grant not answered");
  grant_block_a: assert property (
    br_out != 4'h0 || sack_out || bbsy_out |-> !bg_out)
    else $error("grant passed while busy");
  master_hold_a: assert property (
    intr_out && !ssyn_in |=> intr_out && bbsy_out)
    else $error("bus dropped before strobe");
  strobe_release_a: assert property (
    s_strobe |=> !intr_out && bg_out == bg_in)
    else $error("bus kept after strobe");

  // ****************************************************************
  // Status and vector checks
  // ****************************************************************
  error_shown_a: assert property (
    offline_q |-> status_word[CRIRQ_B_ERROR])
    else $error("offline not shown");
  error_term_a: assert property (
    overrun_flag && card_complete_q |-> status_word[CRIRQ_B_ERROR])
    else $error("overrun error not shown");
  read_hidden_a: assert property (
    status_sel && status_rd |=> !bus_rdata[CRIRQ_B_READ])
    else $error("read flop visible");
  done_shown_a: assert property (
    card_complete_q |-> status_word[CRIRQ_B_DONE])
    else $error("card done not shown");
  online_shown_a: assert property (
    went_online_q |-> status_word[CRIRQ_B_ONLINE])
    else $error("online not shown");
  vector_full_a: assert property (
    intr_out |-> vector_out == CRIRQ_VEC_DEFAULT)
    else $error("vector word wrong");
  // Checked through the clear itself, so the default disable is switched off here
  init_clear_a: assert property (disable iff (1'b0)
    clr |=> !card_complete_q && !offline_q && !int_enable_q && !read_cmd
    && br_out == 4'h0 && !slave_ack) else $error("initialize left state");
endmodule : crirq_core
`default_nettype wire

// ### verif/crirq_arb_model.sv
// Behavioural bus arbiter and interrupt-servicing processor for the card reader block
`timescale 1ns/100ps
`default_nettype none
module crirq_arb_model
  import crirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] br_out,
  input wire logic sack_out,
  input wire logic intr_out,
  input wire logic [7:0] vector_out,
  input wire logic slow,
  input wire logic force_bg,
  output logic bg_in,
  output logic bbsy_in,
  output logic ssyn_in,
  output logic vec_seen,
  output logic [7:0] vec_got
);
  logic grant_q = 1'b0;

  // Stray grant lets the bench see the pass-through while nothing is requested
  assign bg_in = grant_q | force_bg;

  initial begin
    int n;
    bbsy_in = 1'b0;
    ssyn_in = 1'b0;
    vec_seen = 1'b0;
    vec_got = 8'h00;
    forever begin
      @(posedge clk);
      if (br_out[CRIRQ_PRIO_PLUG] === 1'b1 && sys_rst === 1'b0) begin
        if (slow) repeat (5) @(posedge clk);
        grant_q <= 1'b1;
        n = 0;
        while (sack_out !== 1'b1 && n < 50) begin
          @(posedge clk);
          n++;
        end
        grant_q <= 1'b0;
        // A slow bus keeps the previous master busy for a while after SACK
        if (slow) begin
          bbsy_in <= 1'b1;
          repeat (3) @(posedge clk);
          bbsy_in <= 1'b0;
        end
        n = 0;
        while (intr_out !== 1'b1 && n < 50) begin
          @(posedge clk);
          n++;
        end
        vec_got <= vector_out;
        vec_seen <= 1'b1;
        @(posedge clk);
        vec_seen <= 1'b0;
        ssyn_in <= 1'b1;
        n = 0;
        while (intr_out !== 1'b0 && n < 50) begin
          @(posedge clk);
          n++;
        end
        ssyn_in <= 1'b0;
      end
    end
  end
endmodule : crirq_arb_model
`default_nettype wire

// ### verif/crirq_core_tb.sv
// Self-checking bench for the card reader interrupt and status block
`timescale 1ns/100ps
`default_nettype none
module crirq_core_tb
  import crirq_pkg::*;
();
  logic clk = 1'b0, sys_rst = 1'b1, bus_init = 1'b0, ack_inhibit_strap = 1'b1;
  logic status_sel = 1'b0, status_rd = 1'b0, status_wr_lo = 1'b0;
  logic [15:0] bus_wdata = 16'h0000;
  logic reader_ready_line = 1'b0, card_in_reader = 1'b0, index_marker = 1'b0;
  logic column_available_flag = 1'b0, overrun_flag = 1'b0, npr_sample_jumper = 1'b0;
  logic npr_in = 1'b0, slow = 1'b0, force_bg = 1'b0, ack_prev_q = 1'b0;
  logic bg_in, bbsy_in, ssyn_in, vec_seen, bg_out, sack_out, bbsy_out, intr_out;
  logic slave_ack, read_cmd;
  logic [15:0] bus_rdata;
  logic [3:0] br_out;
  logic [7:0] vector_out, vec_got;
  logic [15:0] rd_q[$];
  logic [7:0] vec_q[$];
  int error_cnt = 0, checks_done = 0;

  always #50 clk = ~clk;

  crirq_core i_dut (.clk, .sys_rst, .bus_init, .ack_inhibit_strap, .status_sel, .status_rd,
    .status_wr_lo, .bus_wdata, .bus_rdata, .slave_ack, .reader_ready_line, .card_in_reader,
    .index_marker, .column_available_flag, .overrun_flag, .read_cmd, .npr_sample_jumper,
    .npr_in, .bg_in, .bbsy_in, .ssyn_in, .br_out, .bg_out, .sack_out, .bbsy_out, .intr_out,
    .vector_out);
  crirq_arb_model i_arb (.clk, .sys_rst, .br_out, .sack_out, .intr_out, .vector_out, .slow,
    .force_bg, .bg_in, .bbsy_in, .ssyn_in, .vec_seen, .vec_got);

  // ****************************************************************
  // Compare and bus tasks
  // ****************************************************************
  task automatic bad(input string msg);
    error_cnt++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("status %h expected %h", got, exp));
  endtask : cmp_word
  task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("vector %h expected %h", got, exp));
  endtask : cmp_vec
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) bad(what);
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Holds the cycle until the acknowledge is sampled, or gives up when it never comes
  task automatic bus(input logic wr, input logic [15:0] d, input logic [15:0] exp);
    logic seen;
    seen = 1'b0;
    cyc(3);
    status_sel <= 1'b1;
    status_rd <= !wr;
    status_wr_lo <= wr;
    bus_wdata <= {8'($urandom), d[7:0]};
    if (!wr) rd_q.push_back(exp);
    repeat (6) if (!seen) begin
      @(posedge clk);
      seen = (slave_ack === 1'b1);
    end
    status_sel <= 1'b0;
    status_rd <= 1'b0;
    status_wr_lo <= 1'b0;
    chk_bit(seen, ack_inhibit_strap, "acknowledge");
    cyc(2);
  endtask : bus
  task automatic rd(input logic [15:0] exp);
    bus(1'b0, 16'h0000, exp);
  endtask : rd
  task automatic wr(input logic [15:0] d);
    bus(1'b1, d, 16'h0000);
  endtask : wr
  task automatic take_irq();
    int n;
    vec_q.push_back(CRIRQ_VEC_DEFAULT);
    n = 0;
    while (br_out === 4'h0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk_bit(br_out === 4'h4, 1'b1, "request level");
    // Only a grant that is really present can show whether it is kept back
    n = 0;
    while (bg_in !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk_bit(bg_out, 1'b0, "grant held");
    n = 0;
    while (vec_q.size() != 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    cyc(4);
  endtask : take_irq
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge clk) begin
    ack_prev_q <= slave_ack;
    if (slave_ack === 1'b1 && ack_prev_q !== 1'b1 && status_rd === 1'b1) begin
      if (rd_q.size() == 0) bad("unexpected read data");
      else cmp_word(bus_rdata, rd_q.pop_front());
    end
    if (vec_seen === 1'b1) begin
      if (vec_q.size() == 0) bad("unexpected interrupt");
      else cmp_vec(vec_got, vec_q.pop_front());
    end
  end

  initial begin
    cyc(5000);
    error_cnt++;
    close_out();
  end

  initial begin
    void'($urandom(32'hBE1240D3));
    cyc(16);
    sys_rst <= 1'b0;
    rd(CRIRQ_ST_RESET);
    reader_ready_line <= 1'b1;
    rd(16'h0400);
    wr(16'h0001);
    chk_bit(read_cmd, 1'b1, "read command");
    rd(16'h0000);
    reader_ready_line <= 1'b0;
    cyc(3);
    chk_bit(read_cmd, 1'b0, "read cleared on drop");
    rd(16'h8000);
    wr(16'h0001);
    rd(16'h8000);
    chk_bit(read_cmd, 1'b0, "read blocked");
    wr(16'h0000);
    rd(16'h0000);
    $display("test error interlock done");
    card_in_reader <= 1'b1;
    cyc(2);
    card_in_reader <= 1'b0;
    rd(16'h4000);
    overrun_flag <= 1'b1;
    rd(16'hC000);
    overrun_flag <= 1'b0;
    column_available_flag <= 1'b1;
    rd(16'h4080);
    column_available_flag <= 1'b0;
    wr(16'h0000);
    ack_inhibit_strap <= 1'b0;
    wr(16'h0040);
    ack_inhibit_strap <= 1'b1;
    rd(16'h0040);
    $display("test status flags done");
    force_bg <= 1'b1;
    cyc(2);
    chk_bit(bg_out, 1'b1, "grant pass");
    force_bg <= 1'b0;
    column_available_flag <= 1'b1;
    take_irq();
    cyc(20);
    chk_bit(br_out === 4'h0, 1'b1, "no repeat request");
    column_available_flag <= 1'b0;
    cyc(2);
    slow <= 1'b1;
    column_available_flag <= 1'b1;
    take_irq();
    column_available_flag <= 1'b0;
    slow <= 1'b0;
    npr_sample_jumper <= 1'b1;
    npr_in <= 1'b1;
    cyc(2);
    column_available_flag <= 1'b1;
    cyc(10);
    chk_bit(br_out === 4'h0, 1'b1, "held off by npr");
    npr_in <= 1'b0;
    take_irq();
    $display("test interrupts done");
    column_available_flag <= 1'b0;
    bus_init <= 1'b1;
    cyc(1);
    bus_init <= 1'b0;
    rd(16'h0000);
    chk_bit(vec_q.size() == 0 && rd_q.size() == 0, 1'b1, "results missing");
    $display("test bus init done");
    close_out();
  end
endmodule : crirq_core_tb
`default_nettype wire
